// *** fault_report_pkg.sv ***
package fault_report_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int PAR_W  = 12;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [17:0] IDX_FAULT_CLEAR   = 18'h0f421;
  localparam logic [17:0] IDX_PARITY        = 18'h0f422;
  localparam logic [17:0] IDX_SW_SUPPRESS   = 18'h0f423;
  localparam logic [17:0] IDX_WD_SUPPRESS   = 18'h0f424;
  localparam logic [17:0] IDX_STACK_SUPPRESS = 18'h0f425;
  localparam logic [17:0] IDX_LOOP_SUPPRESS = 18'h0f426;
  localparam logic [17:0] IDX_FAULT_LATCH   = 18'h0f427;
  localparam logic [17:0] IDX_FAULT_SOURCE  = 18'h0f428;
  localparam logic [17:0] IDX_EVENT_STATUS  = 18'h0f42e;
  localparam logic [17:0] IDX_EVENT_ENABLE  = 18'h0f42f;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [PAR_W-1:0] PARITY_RESET   = 12'h003;
  localparam logic             SUPPRESS_RESET = 1'b0;
  localparam logic [REG_W-1:0] FAULT_RESET    = 16'h0000;
  localparam logic [REG_W-1:0] ENABLE_RESET   = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions: clear and suppress bits, then those shared by fault source, status and enable
  // ----------------------------------------------------------------
  localparam int POS_CLEAR       = 0;
  localparam int POS_SUPPRESS    = 0;
  localparam int POS_RATE_CONV0  = 0;
  localparam int POS_PMEM0       = 2;
  localparam int POS_DMEM0_BANK0 = 4;
  localparam int POS_DMEM1_BANK3 = 11;
  localparam int POS_WD          = 12;
  localparam int POS_STACK       = 13;
  localparam int POS_LOOP        = 14;
  localparam int POS_SOFT        = 15;

  // ----------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             we;
    logic [REG_W-1:0] wdata;
  } sw_write_type;

  typedef struct packed {
    logic             flag;
    logic [REG_W-1:0] source;
  } capture_state_type;

  typedef struct packed {
    logic [REG_W-1:0] status;
    logic             irq;
  } event_state_type;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
    logic              clear_bit;
    logic [PAR_W-1:0]  parity;
    logic              sw_fault_suppress;
    logic              wd_fault_suppress;
    logic              stack_fault_suppress;
    logic              loop_fault_suppress;
    logic [REG_W-1:0]  enable;
  } regs_state_type;

endpackage

// *** fault_capture.sv ***
`timescale 1ns/1ps
module fault_capture
  import fault_report_pkg::*;
(
  input  logic                    pclk,
  input  logic                    presetn,
  input  logic [REG_W-1:0]        reported,
  input  logic                    clear_rise,
  output capture_state_type       cap
);

  capture_state_type next_cap;
  logic              held;

  always_comb begin
    held     = cap.flag & ~clear_rise;
    next_cap = cap;
    if (clear_rise) begin
      next_cap.flag   = 1'b0;
      next_cap.source = FAULT_RESET;
    end
    // Error in the clearing cycle is kept as the new first one
    if (!held && (|reported)) begin
      next_cap.flag   = 1'b1;
      next_cap.source = reported & (~reported + 16'h0001);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap <= '0;
    end else begin
      cap <= next_cap;
    end
  end

endmodule

// *** event_status.sv ***
`timescale 1ns/1ps
module event_status
  import fault_report_pkg::*;
(
  input  logic                    pclk,
  input  logic                    presetn,
  input  logic [REG_W-1:0]        events,
  input  logic [REG_W-1:0]        enable,
  input  sw_write_type            w1c,
  output event_state_type         evt
);

  event_state_type  next_evt;
  logic [REG_W-1:0] cleared;

  always_comb begin
    cleared         = w1c.we ? w1c.wdata : 16'h0000;
    next_evt        = evt;
    // Set wins over a clear in the same cycle
    next_evt.status = (evt.status & ~cleared) | events;
    next_evt.irq    = |(next_evt.status & enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt <= '0;
    end else begin
      evt <= next_evt;
    end
  end

endmodule

// *** fault_report_manager.sv ***
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
// How it works
// - Parity bits 6..4 suppress data memory 0 banks 2..0 when one, report them when zero.
// - Parity bits 3 and 2 suppress program memories 1 and 0 when one, report them when zero.
// - Parity bits 1 and 0 cover rate converters 1 and 0 and come out of reset set.
// - Bit 0 of the software suppress register hides software faults and resets to zero.
// - Bit 0 of the watchdog suppress register hides watchdog faults and resets to zero.
// - Bit 0 of the stack suppress register hides stack faults and resets to zero.
// - Bit 0 of the loop suppress register hides loop overrun faults and resets to zero.
// - Any unsuppressed fault raises the master flag in the latch register.
// - The master flag stays high until a clear, and resets low.
// - Only the first reported fault is captured; later ones leave the source alone.
// - Source bits 15..12 mean software, loop, stack and watchdog faults.
// - A clear empties the source and re-arms capture of a new first fault.
// - The clear happens only on a zero-to-one change of clear bit 0.
// - Parity bits 11..7 cover data memory 1 banks 3..0 and data memory 0 bank 3.
// - Source bits 11..0 follow the same layout as the parity bits.
module fault_report_manager
  import fault_report_pkg::*;
(
  input  logic              pclk,
  input  logic              presetn,
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [ADDR_W-1:0] paddr,
  input  logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic              pready,
  output logic              pslverr,
  input  logic [REG_W-1:0]  fault_report,
  output logic              fault_flag,
  output logic              irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  regs_state_type    st;
  regs_state_type    next_st;
  capture_state_type cap;
  event_state_type   evt;
  sw_write_type      status_w1c;
  logic [17:0]       idx;
  logic              access;
  logic              wr;
  logic              mapped;
  logic              wr_clear;
  logic              clear_rise;
  logic [REG_W-1:0]  suppress;
  logic [REG_W-1:0]  unsup;
  logic [DATA_W-1:0] rd_value;

  assign idx    = paddr[19:2];
  assign access = psel & penable;
  assign wr     = access & st.pready & pwrite;

  // ----------------------------------------------------------------
  // Suppression vector, one bit per fault source
  // ----------------------------------------------------------------
  always_comb begin
    suppress                  = 16'h0000;
    suppress[PAR_W-1:0]       = st.parity;
    suppress[POS_WD]          = st.wd_fault_suppress;
    suppress[POS_STACK]       = st.stack_fault_suppress;
    suppress[POS_LOOP]        = st.loop_fault_suppress;
    suppress[POS_SOFT]        = st.sw_fault_suppress;
  end

  assign unsup = fault_report & ~suppress;

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  always_comb begin
    mapped   = 1'b1;
    rd_value = 32'h0000_0000;
    case (idx)
      IDX_FAULT_CLEAR:    rd_value[POS_CLEAR]    = st.clear_bit;
      IDX_PARITY:         rd_value[PAR_W-1:0]    = st.parity;
      IDX_SW_SUPPRESS:    rd_value[POS_SUPPRESS] = st.sw_fault_suppress;
      IDX_WD_SUPPRESS:    rd_value[POS_SUPPRESS] = st.wd_fault_suppress;
      IDX_STACK_SUPPRESS: rd_value[POS_SUPPRESS] = st.stack_fault_suppress;
      IDX_LOOP_SUPPRESS:  rd_value[POS_SUPPRESS] = st.loop_fault_suppress;
      IDX_FAULT_LATCH:    rd_value[POS_CLEAR]    = cap.flag;
      IDX_FAULT_SOURCE:   rd_value[REG_W-1:0]    = cap.source;
      IDX_EVENT_STATUS:   rd_value[REG_W-1:0]    = evt.status;
      IDX_EVENT_ENABLE:   rd_value[REG_W-1:0]    = st.enable;
      default:            mapped                 = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Clear edge and status write-one-to-clear
  // ----------------------------------------------------------------
  assign wr_clear   = wr & mapped & (idx == IDX_FAULT_CLEAR);
  // Writing one over a one is no edge, so nothing is cleared
  assign clear_rise = wr_clear & pwdata[POS_CLEAR] & ~st.clear_bit;

  assign status_w1c.we    = wr & (idx == IDX_EVENT_STATUS);
  assign status_w1c.wdata = pwdata[REG_W-1:0];

  // ----------------------------------------------------------------
  // APB slave and register file
  // ----------------------------------------------------------------
  // One wait state: answer data is sampled one cycle before the
  // completing edge, so a fault landing in between shows next read.
  always_comb begin
    next_st         = st;
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    if (access && !st.pready) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = ~mapped;
      next_st.prdata  = pwrite ? 32'h0000_0000 : rd_value;
    end
    if (wr && mapped) begin
      case (idx)
        IDX_FAULT_CLEAR:    next_st.clear_bit            = pwdata[POS_CLEAR];
        IDX_PARITY:         next_st.parity               = pwdata[PAR_W-1:0];
        IDX_SW_SUPPRESS:    next_st.sw_fault_suppress    = pwdata[POS_SUPPRESS];
        IDX_WD_SUPPRESS:    next_st.wd_fault_suppress    = pwdata[POS_SUPPRESS];
        IDX_STACK_SUPPRESS: next_st.stack_fault_suppress = pwdata[POS_SUPPRESS];
        IDX_LOOP_SUPPRESS:  next_st.loop_fault_suppress  = pwdata[POS_SUPPRESS];
        IDX_EVENT_ENABLE:   next_st.enable               = pwdata[REG_W-1:0];
        default:            next_st.enable               = st.enable;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st                      <= '0;
      st.parity               <= PARITY_RESET;
      st.sw_fault_suppress    <= SUPPRESS_RESET;
      st.wd_fault_suppress    <= SUPPRESS_RESET;
      st.stack_fault_suppress <= SUPPRESS_RESET;
      st.loop_fault_suppress  <= SUPPRESS_RESET;
      st.enable               <= ENABLE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // First-fault capture and event status
  // ----------------------------------------------------------------
  fault_capture u_capture (
    .pclk       (pclk),
    .presetn    (presetn),
    .reported   (unsup),
    .clear_rise (clear_rise),
    .cap        (cap)
  );

  event_status u_events (
    .pclk    (pclk),
    .presetn (presetn),
    .events  (unsup),
    .enable  (st.enable),
    .w1c     (status_w1c),
    .evt     (evt)
  );

  assign prdata     = st.prdata;
  assign pready     = st.pready;
  assign pslverr    = st.pslverr;
  assign fault_flag = cap.flag;
  assign irq        = evt.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_DMEM0_LOW_REPORT: assert property (
    !cap.flag && |(fault_report[POS_DMEM0_BANK0+2:POS_DMEM0_BANK0]
                   & ~st.parity[POS_DMEM0_BANK0+2:POS_DMEM0_BANK0])
    |=> cap.flag)
    else $error("unsuppressed data memory 0 fault did not raise the flag");

  AST_PMEM_REPORT: assert property (
    !cap.flag && |(fault_report[POS_PMEM0+1:POS_PMEM0] & ~st.parity[POS_PMEM0+1:POS_PMEM0])
    |=> cap.flag && |cap.source[POS_PMEM0+1:0])
    else $error("unsuppressed program memory fault not captured");

  AST_RATE_CONV_RESET: assert property (
    $rose(presetn) |-> st.parity[POS_RATE_CONV0+1:POS_RATE_CONV0] == 2'b11)
    else $error("rate converter suppress bits not set after reset");

  AST_SW_CAPTURE: assert property (
    !cap.flag && unsup == 16'h8000 && !clear_rise |=> cap.source == 16'h8000)
    else $error("software fault not captured in bit 15");

  AST_WD_CAPTURE: assert property (
    !cap.flag && unsup == 16'h1000 |=> cap.flag && cap.source == 16'h1000)
    else $error("watchdog fault not captured in bit 12");

  AST_STACK_SUPPRESSED: assert property (
    !cap.flag && st.stack_fault_suppress && (fault_report & ~16'h2000 & ~suppress) == 16'h0000
    |=> !cap.flag)
    else $error("suppressed stack fault raised the flag");

  AST_LOOP_CAPTURE: assert property (
    !cap.flag && unsup == 16'h4000 |=> cap.source[POS_LOOP] && $onehot(cap.source))
    else $error("loop fault not captured in bit 14");

  AST_FLAG_SET: assert property (
    |unsup |=> cap.flag)
    else $error("master flag not raised by a reported fault");

  AST_FLAG_STICKY: assert property (
    cap.flag && !clear_rise |=> cap.flag)
    else $error("master flag dropped without a clear");

  AST_SOURCE_HELD: assert property (
    cap.flag && !clear_rise |=> $stable(cap.source))
    else $error("fault source changed after the first fault");

  AST_SOURCE_ONEHOT: assert property (
    cap.flag |-> $onehot(cap.source))
    else $error("fault source not one-hot while flagged");

  AST_DMEM1_BANK3: assert property (
    !cap.flag && unsup == 16'h0800 |=> cap.source == 16'h0800)
    else $error("data memory 1 bank 3 fault not in bit 11");

  AST_CLEAR_EMPTIES: assert property (
    clear_rise && unsup == 16'h0000 |=> !cap.flag && cap.source == 16'h0000)
    else $error("clear did not empty the fault manager");

  AST_CLEAR_EDGE_ONLY: assert property (
    wr_clear && st.clear_bit && cap.flag |=> cap.flag)
    else $error("clear fired without a rising edge");

  // Lower sources must be quiet, since the lowest reported bit wins
  AST_DMEM_HIGH_REPORT: assert property (
    !cap.flag && unsup[POS_DMEM0_BANK0+2:0] == 7'h00
    && |(fault_report[PAR_W-1:POS_DMEM0_BANK0+3] & ~st.parity[PAR_W-1:POS_DMEM0_BANK0+3])
    |=> cap.flag && |cap.source[PAR_W-1:POS_DMEM0_BANK0+3])
    else $error("upper data memory fault not captured");

  AST_SOURCE_FROM_REPORT: assert property (
    !cap.flag && |unsup |=> (cap.source & $past(unsup)) == cap.source)
    else $error("captured source was not among reported faults");

  AST_SUPPRESSED_IGNORED: assert property (
    !cap.flag && (fault_report & ~{st.sw_fault_suppress, st.loop_fault_suppress,
                  st.stack_fault_suppress, st.wd_fault_suppress, st.parity}) == 16'h0000
    |=> !cap.flag ##0 cap.source == 16'h0000)
    else $error("suppressed fault reached the fault manager");

  AST_APB_ANSWER: assert property (
    access && !pready |=> pready ##1 !pready)
    else $error("APB answer not one cycle after access start");

  AST_IRQ_LEVEL: assert property (
    |(evt.status & st.enable) && !status_w1c.we |=> irq)
    else $error("interrupt low with an enabled status bit set");

  // ----------------------------------------------------------------
  // Bus answer checks
  // ----------------------------------------------------------------
  AST_PREADY_ONE_CYCLE: assert property (
    pready |=> !pready)
    else $error("pready stood longer than one cycle");

  AST_SLVERR_WITH_READY: assert property (
    pslverr |-> pready)
    else $error("pslverr high without pready");

  AST_UNMAPPED_ERROR: assert property (
    access && !pready && !mapped |=> pslverr)
    else $error("unmapped access answered without an error");

  AST_WRITE_READS_ZERO: assert property (
    access && !pready && pwrite |=> prdata == 32'h0000_0000)
    else $error("write answered with nonzero read data");

  AST_LATCH_READ: assert property (
    access && !pready && !pwrite && idx == IDX_FAULT_LATCH
    |=> prdata == {31'h0, $past(fault_flag)})
    else $error("latch read did not return the master flag");

  // ----------------------------------------------------------------
  // Register stores, seen one edge after the completing edge
  // ----------------------------------------------------------------
  AST_PARITY_STORE: assert property (
    wr && idx == IDX_PARITY
    |=> {20'h00000, st.parity} == ($past(pwdata) & 32'h0000_0fff))
    else $error("parity suppress write did not land");

  AST_SW_STORE: assert property (
    wr && idx == IDX_SW_SUPPRESS
    |=> {31'h0, st.sw_fault_suppress} == ($past(pwdata) & 32'h0000_0001))
    else $error("software suppress write did not land");

  AST_WD_STORE: assert property (
    wr && idx == IDX_WD_SUPPRESS
    |=> {31'h0, st.wd_fault_suppress} == ($past(pwdata) & 32'h0000_0001))
    else $error("watchdog suppress write did not land");

  AST_STACK_STORE: assert property (
    wr && idx == IDX_STACK_SUPPRESS
    |=> {31'h0, st.stack_fault_suppress} == ($past(pwdata) & 32'h0000_0001))
    else $error("stack suppress write did not land");

  AST_LOOP_STORE: assert property (
    wr && idx == IDX_LOOP_SUPPRESS
    |=> {31'h0, st.loop_fault_suppress} == ($past(pwdata) & 32'h0000_0001))
    else $error("loop suppress write did not land");

  AST_CLEAR_STORE: assert property (
    wr_clear
    |=> {31'h0, st.clear_bit} == ($past(pwdata) & 32'h0000_0001))
    else $error("clear bit write did not land");

  // ----------------------------------------------------------------
  // Capture and event checks
  // ----------------------------------------------------------------
  AST_SOURCE_EMPTY_IDLE: assert property (
    !cap.flag |-> cap.source == 16'h0000)
    else $error("fault source not empty while unflagged");

  AST_STATUS_SET: assert property (
    |unsup |=> (evt.status & $past(unsup)) == $past(unsup))
    else $error("reported fault did not set its status bit");

  AST_STATUS_W1C: assert property (
    status_w1c.we && unsup == 16'h0000
    |=> ({16'h0000, evt.status} & $past(pwdata)) == 32'h0000_0000)
    else $error("status bit survived a write of one");

  AST_IRQ_QUIET: assert property (
    (evt.status & st.enable) == 16'h0000 && unsup == 16'h0000 |=> !irq)
    else $error("interrupt high with no enabled status bit");

  COV_FIRST_FAULT: cover property (!cap.flag ##1 cap.flag);
  COV_CLEAR: cover property (cap.flag && clear_rise);
  COV_SUPPRESSED: cover property (|fault_report && unsup == 16'h0000);
  COV_IRQ: cover property ($rose(irq));
  COV_HELD_ONE_WRITE: cover property (wr_clear && st.clear_bit);

endmodule

// *** fault_report_manager_tb.sv ***
`timescale 1ns/1ps
module fault_report_manager_tb;
  import fault_report_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic [REG_W-1:0]  fault_report;
  logic              fault_flag;
  logic              irq;
  int                n_fail = 0;
  int                checks = 0;
  int                cycles = 0;
  logic [31:0]       rd;
  logic              err;
  logic [PAR_W-1:0]  par_sh;

  fault_report_manager u_dut (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .fault_report (fault_report),
    .fault_flag   (fault_flag),
    .irq          (irq)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Timeout: the whole sequence needs well under 3000 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [17:0] idx, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic serr);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // No local limit: only the bench timeout ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [17:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd, rd, err);
    chk1("write pslverr", 1'b0, err);
  endtask

  task automatic rd_chk(input logic [17:0] idx, input logic [31:0] exp, input string name);
    apb(1'b0, idx, 32'h0000_0000, rd, err);
    chk1("read pslverr", 1'b0, err);
    chk32(name, exp, rd);
  endtask

  task automatic pulse(input logic [REG_W-1:0] v);
    @(posedge pclk);
    fault_report <= v;
    @(posedge pclk);
    fault_report <= '0;
    @(posedge pclk);
  endtask

  task automatic clear_seq();
    wr(IDX_FAULT_CLEAR, 32'h0000_0001);
    wr(IDX_FAULT_CLEAR, 32'h0000_0000);
  endtask

  // Sources 0..11 share the parity register, 12..15 have their own
  task automatic set_sup(input int i, input logic v);
    logic [17:0] idx;
    if (i < PAR_W) begin
      par_sh[i] = v;
      wr(IDX_PARITY, {20'h00000, par_sh});
    end else begin
      idx = (i == POS_WD) ? IDX_WD_SUPPRESS : (i == POS_STACK) ? IDX_STACK_SUPPRESS :
            (i == POS_LOOP) ? IDX_LOOP_SUPPRESS : IDX_SW_SUPPRESS;
      wr(idx, {31'h0, v});
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    fault_report = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(IDX_FAULT_CLEAR, 32'h0, "clear reset");
    rd_chk(IDX_PARITY, 32'h3, "parity reset");
    for (int k = 0; k < 4; k++) rd_chk(18'(IDX_SW_SUPPRESS + k), 32'h0, "suppress reset");
    rd_chk(IDX_FAULT_LATCH, 32'h0, "latch reset");
    rd_chk(IDX_FAULT_SOURCE, 32'h0, "source reset");
    apb(1'b1, 18'h0f430, 32'hffff_ffff, rd, err);
    chk1("unmapped write err", 1'b1, err);
    apb(1'b0, 18'h0f430, 32'h0, rd, err);
    chk1("unmapped read err", 1'b1, err);
    chk32("unmapped read data", 32'h0, rd);
    // Everything suppressed: a full burst of reports must leave no trace
    par_sh = 12'hfff;
    wr(IDX_PARITY, 32'hffff_ffff);
    for (int k = 0; k < 4; k++) wr(18'(IDX_SW_SUPPRESS + k), 32'hffff_ffff);
    rd_chk(IDX_PARITY, 32'h0000_0fff, "parity width");
    rd_chk(IDX_LOOP_SUPPRESS, 32'h1, "loop width");
    pulse(16'hffff);
    chk1("flag all suppressed", 1'b0, fault_flag);
    rd_chk(IDX_FAULT_SOURCE, 32'h0, "source all suppressed");
    // One source open at a time proves each suppress bit and source bit
    for (int i = 0; i < REG_W; i++) begin
      set_sup(i, 1'b0);
      pulse(16'hffff);
      chk1("flag open source", 1'b1, fault_flag);
      rd_chk(IDX_FAULT_SOURCE, 32'h1 << i, "source one-hot");
      rd_chk(IDX_FAULT_LATCH, 32'h1, "latch set");
      chk1("irq disabled", 1'b0, irq);
      set_sup(i, 1'b1);
      clear_seq();
      chk1("flag cleared", 1'b0, fault_flag);
      rd_chk(IDX_FAULT_SOURCE, 32'h0, "source cleared");
    end
    par_sh = '0;
    wr(IDX_PARITY, 32'h0);
    for (int k = 0; k < 4; k++) wr(18'(IDX_SW_SUPPRESS + k), 32'h0);
    pulse(16'h0020);
    pulse(16'h0008);
    pulse(16'h1000);
    rd_chk(IDX_FAULT_SOURCE, 32'h0020, "first fault kept");
    repeat (20) @(posedge pclk);
    chk1("flag sticky", 1'b1, fault_flag);
    wr(IDX_FAULT_SOURCE, 32'hffff);
    wr(IDX_FAULT_LATCH, 32'h0);
    rd_chk(IDX_FAULT_SOURCE, 32'h0020, "source read-only");
    rd_chk(IDX_FAULT_LATCH, 32'h1, "latch read-only");
    // Clear acts on the zero-to-one change only
    wr(IDX_FAULT_CLEAR, 32'h1);
    rd_chk(IDX_FAULT_SOURCE, 32'h0, "rise clears");
    pulse(16'h0100);
    wr(IDX_FAULT_CLEAR, 32'h1);
    rd_chk(IDX_FAULT_SOURCE, 32'h0100, "held one no clear");
    rd_chk(IDX_FAULT_CLEAR, 32'h1, "clear bit stored");
    wr(IDX_FAULT_CLEAR, 32'h0);
    rd_chk(IDX_FAULT_SOURCE, 32'h0100, "fall no clear");
    chk1("flag after fall", 1'b1, fault_flag);
    clear_seq();
    pulse(16'hc010);
    rd_chk(IDX_FAULT_SOURCE, 32'h0010, "simultaneous lowest");
    clear_seq();
    // Event status, enable and the level interrupt
    wr(IDX_EVENT_STATUS, 32'hffff);
    rd_chk(IDX_EVENT_STATUS, 32'h0, "status w1c");
    pulse(16'h1000);
    rd_chk(IDX_EVENT_STATUS, 32'h1000, "status set");
    chk1("irq masked", 1'b0, irq);
    wr(IDX_EVENT_ENABLE, 32'h1000);
    repeat (2) @(posedge pclk);
    chk1("irq enabled", 1'b1, irq);
    rd_chk(IDX_EVENT_ENABLE, 32'h0000_1000, "enable readback");
    wr(IDX_EVENT_STATUS, 32'h0800);
    repeat (2) @(posedge pclk);
    chk1("irq other bit", 1'b1, irq);
    wr(IDX_EVENT_STATUS, 32'h1000);
    repeat (2) @(posedge pclk);
    chk1("irq cleared", 1'b0, irq);
    rd_chk(IDX_EVENT_STATUS, 32'h0, "status cleared");
    print_verdict();
  end

endmodule
